/* verilog/tcds_pkg.sv */
// Package for the transparent clock dataset register bank.
// Assumes a single core clock and a simple word-wide register port.
package tcds_pkg;

    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 32;

    // Register offsets
    localparam logic [15:0] OFS_DEF_CTRL    = 16'h1900;
    localparam logic [15:0] OFS_IDENT_LO    = 16'h1904;
    localparam logic [15:0] OFS_IDENT_HI    = 16'h1908;
    localparam logic [15:0] OFS_DOMAIN      = 16'h190c;
    localparam logic [15:0] OFS_PORT_COUNT  = 16'h191c;
    localparam logic [15:0] OFS_PORT_CTRL   = 16'h1a00;
    localparam logic [15:0] OFS_DELAY_HI    = 16'h1a04;
    localparam logic [15:0] OFS_DELAY_LO    = 16'h1a08;
    localparam logic [15:0] OFS_LOG_PERIOD  = 16'h1a10;
    localparam logic [15:0] OFS_SKEW        = 16'h1a1c;
    localparam logic [15:0] OFS_LIMIT       = 16'h1a20;

    // Control field positions
    localparam int          BIT_DONE        = 31;
    localparam int          BIT_READ        = 30;
    localparam int          BIT_DOMAIN_VAL  = 1;
    localparam int          BIT_IDENT_VAL   = 0;
    localparam int          BIT_SKEW_VAL    = 2;
    localparam int          BIT_INTV_VAL    = 1;
    localparam int          BIT_MECH_VAL    = 0;
    localparam int          SEL_LSB         = 16;
    localparam int          SEL_W           = 8;
    localparam int          SCALED_SHIFT    = 16;

    // Reset values and profile code
    localparam logic [31:0] RST_WORD        = 32'h0000_0000;
    localparam logic [1:0]  PROFILE_TSN     = 2'h3;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } tcds_bus_req_t;

    typedef struct packed {
        logic [63:0] identity;
        logic [47:0] mac;
        logic [7:0]  domain;
        logic        identity_load;
        logic        domain_load;
        logic [7:0]  port_select;
        logic [7:0]  log_period;
        logic [31:0] skew;
        logic [31:0] limit;
        logic        skew_load;
        logic        interval_load;
        logic        mechanism_load;
    } tcds_cfg_t;

    typedef struct packed {
        logic pend;
        logic done;
        logic take;
    } tcds_snap_st_t;

endpackage : tcds_pkg

/* verilog/tcds_snap.sv */
// Snapshot request and done flag pair.
// Assumes req pulses for one cycle on a software write of one to the request bit.
`timescale 1ns/100ps
module tcds_snap
    import tcds_pkg::*;
(
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic req,
    output logic      pend,
    output logic      done,
    output logic      take
);
    tcds_snap_st_t st;
    tcds_snap_st_t next_st;

    always_comb begin
        next_st      = st;
        next_st.take = st.pend;
        if (st.pend) begin
            next_st.pend = 1'b0;
            next_st.done = 1'b1;
        end
        if (req) begin
            next_st.pend = 1'b1;
            next_st.done = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pend = st.pend;
    assign done = st.done;
    assign take = st.take;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    AST_SNAP_AUTOCLEAR: assert property (pend && !req |=> !pend)
        else $error("request bit not cleared");
    AST_SNAP_DONE: assert property (pend && !req |=> take && done)
        else $error("done not set after capture");
    AST_SNAP_REQ_CLEARS_DONE: assert property (req ##1 !req |-> !done ##1 done)
        else $error("done not cleared by new request");
    COV_SNAP_CYCLE: cover property (req ##1 pend ##1 done);
endmodule : tcds_snap

/* verilog/tcds_limit.sv */
// Peer latency validity check against the software limit.
// Assumes the delay is scaled nanoseconds with 16 fraction bits.
`timescale 1ns/100ps
module tcds_limit
    import tcds_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [63:0] delay,
    input  wire logic [31:0] limit,
    input  wire logic [1:0]  profile,
    output logic             delay_ok
);
    logic [47:0] ns;
    logic        next_ok;
    logic        ok_q;

    assign ns = delay[63:SCALED_SHIFT];

    always_comb begin
        next_ok = 1'b1;
        if (profile == PROFILE_TSN) begin
            next_ok = (ns[47:32] == 16'h0000) && (ns[31:0] <= limit);
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ok_q <= 1'b1;
        end else begin
            ok_q <= next_ok;
        end
    end

    assign delay_ok = ok_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    AST_LIMIT_OTHER_PROFILE: assert property (profile != PROFILE_TSN |=> delay_ok)
        else $error("limit applied outside tsn profile");
    AST_LIMIT_OVER: assert property (
        profile == PROFILE_TSN && ns[31:0] > limit |=> !delay_ok)
        else $error("over-limit delay treated as valid");
    COV_LIMIT_FAIL: cover property (profile == PROFILE_TSN ##1 !delay_ok);
endmodule : tcds_limit

/* verilog/tcds_regs.sv */
// Default and port dataset register bank of the transparent clock.
// Assumes one core clock, a one-cycle read/write strobe port and an
// engine that supplies live identity, domain, peer delay and profile.
// Notes on behaviour
// - Read request copies live default dataset, sets done
// - Default read request bit clears itself
// - Valid bits apply identity or domain, self-clear
// - Identity bytes 0..2 form first MAC bytes
// - Identity bytes 5..7 form last MAC bytes
// - One writable eight-bit timing domain
// - Read-only sixteen-bit port count from build
// - Port select picks port for access
// - Port read request self-clears, done on capture
// - Per-setting valid bits gate port updates
// - Peer delay read-only, sixty-four bit split
// - Signed log interval, present only when built
// - Writable signed thirty-two bit link skew
// - Writable peer latency limit, checked under profile
// - Profile code three selects the check
`timescale 1ns/100ps
module tcds_regs
    import tcds_pkg::*;
#(
    parameter int PORT_COUNT    = 3,
    parameter bit VARIABLE_RATE = 1'b1
) (
    input  wire logic          mclk,
    input  wire logic          nrst,
    input  wire tcds_bus_req_t bus_req,
    output logic [31:0]        bus_rdata,
    output logic               bus_ack,
    input  wire logic [63:0]   live_identity,
    input  wire logic [7:0]    live_domain,
    input  wire logic [63:0]   live_peer_delay,
    input  wire logic [1:0]    profile,
    output tcds_cfg_t          cfg,
    output logic               peer_delay_ok
);
    initial begin
        if (PORT_COUNT < 1 || PORT_COUNT > 65535) begin
            $error("PORT_COUNT out of range");
        end
    end

    localparam logic [15:0] PORTS = 16'(PORT_COUNT);

    typedef struct packed {
        logic [63:0] ident;
        logic [7:0]  domain;
        logic        ident_val;
        logic        domain_val;
        logic [7:0]  sel;
        logic [63:0] delay;
        logic [7:0]  log_period;
        logic [31:0] skew;
        logic [31:0] limit;
        logic        skew_val;
        logic        intv_val;
        logic        mech_val;
        logic [31:0] rdata;
        logic        ack;
    } regs_st_t;

    regs_st_t st;
    regs_st_t next_st;

    logic wr_def_ctrl;
    logic wr_port_ctrl;
    logic def_req;
    logic port_req;
    logic def_pend;
    logic def_done;
    logic def_take;
    logic port_pend;
    logic port_done;
    logic port_take;

    assign wr_def_ctrl  = bus_req.wr && bus_req.addr == OFS_DEF_CTRL;
    assign wr_port_ctrl = bus_req.wr && bus_req.addr == OFS_PORT_CTRL;
    assign def_req      = wr_def_ctrl && bus_req.wdata[BIT_READ];
    assign port_req     = wr_port_ctrl && bus_req.wdata[BIT_READ];

    tcds_snap u_def_snap (
        .mclk (mclk),
        .nrst (nrst),
        .req  (def_req),
        .pend (def_pend),
        .done (def_done),
        .take (def_take)
    );

    tcds_snap u_port_snap (
        .mclk (mclk),
        .nrst (nrst),
        .req  (port_req),
        .pend (port_pend),
        .done (port_done),
        .take (port_take)
    );

    function automatic logic [31:0] read_word(input regs_st_t s, input logic [15:0] a,
                                              input logic dp, input logic dd,
                                              input logic pp, input logic pd);
        logic [31:0] w;
        w = RST_WORD;
        unique case (a)
            OFS_DEF_CTRL: begin
                w[BIT_DONE]       = dd;
                w[BIT_READ]       = dp;
                w[BIT_DOMAIN_VAL] = s.domain_val;
                w[BIT_IDENT_VAL]  = s.ident_val;
            end
            OFS_IDENT_LO:   w = s.ident[31:0];
            OFS_IDENT_HI:   w = s.ident[63:32];
            OFS_DOMAIN:     w[7:0] = s.domain;
            OFS_PORT_COUNT: w[15:0] = PORTS;
            OFS_PORT_CTRL: begin
                w[BIT_DONE]                  = pd;
                w[BIT_READ]                  = pp;
                w[SEL_LSB +: SEL_W]          = s.sel;
                w[BIT_SKEW_VAL]              = s.skew_val;
                w[BIT_INTV_VAL]              = s.intv_val;
                w[BIT_MECH_VAL]              = s.mech_val;
            end
            OFS_DELAY_HI:   w = s.delay[63:32];
            OFS_DELAY_LO:   w = s.delay[31:0];
            OFS_LOG_PERIOD: w[7:0] = VARIABLE_RATE ? s.log_period : 8'h00;
            OFS_SKEW:       w = s.skew;
            OFS_LIMIT:      w = s.limit;
            default:        w = RST_WORD;
        endcase
        return w;
    endfunction : read_word

    always_comb begin
        next_st            = st;
        next_st.ack        = bus_req.wr || bus_req.rd;
        next_st.ident_val  = 1'b0;
        next_st.domain_val = 1'b0;
        next_st.skew_val   = 1'b0;
        next_st.intv_val   = 1'b0;
        next_st.mech_val   = 1'b0;
        next_st.rdata      = bus_req.rd ?
                             read_word(st, bus_req.addr, def_pend, def_done,
                                       port_pend, port_done) : st.rdata;
        if (def_take) begin
            next_st.ident  = live_identity;
            next_st.domain = live_domain;
        end
        if (port_take) begin
            next_st.delay  = live_peer_delay;
        end
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                OFS_DEF_CTRL: begin
                    next_st.domain_val = bus_req.wdata[BIT_DOMAIN_VAL];
                    next_st.ident_val  = bus_req.wdata[BIT_IDENT_VAL];
                end
                OFS_IDENT_LO: next_st.ident[31:0]  = bus_req.wdata;
                OFS_IDENT_HI: next_st.ident[63:32] = bus_req.wdata;
                OFS_DOMAIN:   next_st.domain       = bus_req.wdata[7:0];
                OFS_PORT_CTRL: begin
                    next_st.sel      = bus_req.wdata[SEL_LSB +: SEL_W];
                    next_st.skew_val = bus_req.wdata[BIT_SKEW_VAL];
                    next_st.intv_val = bus_req.wdata[BIT_INTV_VAL];
                    next_st.mech_val = bus_req.wdata[BIT_MECH_VAL];
                end
                OFS_LOG_PERIOD: begin
                    if (VARIABLE_RATE) begin
                        next_st.log_period = bus_req.wdata[7:0];
                    end
                end
                OFS_SKEW:  next_st.skew  = bus_req.wdata;
                OFS_LIMIT: next_st.limit = bus_req.wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    tcds_limit u_limit (
        .mclk     (mclk),
        .nrst     (nrst),
        .delay    (st.delay),
        .limit    (st.limit),
        .profile  (profile),
        .delay_ok (peer_delay_ok)
    );

    always_comb begin
        cfg                = '0;
        cfg.identity       = st.ident;
        cfg.mac[23:0]      = st.ident[23:0];
        cfg.mac[47:24]     = st.ident[63:40];
        cfg.domain         = st.domain;
        cfg.identity_load  = st.ident_val;
        cfg.domain_load    = st.domain_val;
        cfg.port_select    = st.sel;
        cfg.log_period     = st.log_period;
        cfg.skew           = st.skew;
        cfg.limit          = st.limit;
        cfg.skew_load      = st.skew_val;
        cfg.interval_load  = st.intv_val && VARIABLE_RATE;
        cfg.mechanism_load = st.mech_val;
    end

    assign bus_rdata = st.rdata;
    assign bus_ack   = st.ack;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    AST_IDENT_VAL_PULSE: assert property (
        wr_def_ctrl && bus_req.wdata[BIT_IDENT_VAL] |=> cfg.identity_load ##1
        (!cfg.identity_load || $past(wr_def_ctrl)))
        else $error("identity valid not a one-cycle pulse");
    AST_DOMAIN_VAL_PULSE: assert property (
        wr_def_ctrl && bus_req.wdata[BIT_DOMAIN_VAL] |=> cfg.domain_load)
        else $error("domain valid did not apply");
    AST_DEF_SNAP_COPY: assert property (
        def_take |=> cfg.identity == $past(live_identity) && cfg.domain == $past(live_domain))
        else $error("default snapshot did not copy live dataset");
    AST_PORT_SNAP_DELAY: assert property (
        port_req ##1 !port_req |=> port_done ##1 st.delay == $past(live_peer_delay))
        else $error("port snapshot failed");
    AST_MAC_BYTES: assert property (
        cfg.mac == {cfg.identity[63:40], cfg.identity[23:0]})
        else $error("mac bytes not taken from identity");
    AST_PORT_COUNT_RO: assert property (
        bus_req.rd && bus_req.addr == OFS_PORT_COUNT |=> bus_ack && bus_rdata == {16'h0000, PORTS})
        else $error("port count readback wrong");
    AST_SEL_WRITE: assert property (
        wr_port_ctrl |=> cfg.port_select == $past(bus_req.wdata[23:16]))
        else $error("port select not written");
    AST_SKEW_GATED: assert property (
        $changed(cfg.skew) |-> $past(bus_req.wr && bus_req.addr == OFS_SKEW))
        else $error("skew changed without write");
    AST_DEF_REQ_AUTOCLEAR: assert property (
        def_req ##1 !def_req |=> !def_pend)
        else $error("default read request not self-cleared");
    AST_LOG_ABSENT: assert property (
        !VARIABLE_RATE |-> cfg.log_period == 8'h00)
        else $error("log interval present without build option");
    AST_DOMAIN_WIDTH: assert property (
        bus_req.rd && bus_req.addr == OFS_DOMAIN |=> bus_rdata[31:8] == 24'h000000)
        else $error("domain reserved bits not zero");
    AST_DONE_CLEARED: assert property (port_req |=> !port_done)
        else $error("port done not cleared by request");
    AST_ACK_PULSE: assert property ((bus_req.wr || bus_req.rd) |=> bus_ack)
        else $error("access not acknowledged");
    AST_NO_ACK_IDLE: assert property (!(bus_req.wr || bus_req.rd) |=> !bus_ack)
        else $error("acknowledge without access");
    AST_IDENT_LO_WRITE: assert property (
        bus_req.wr && bus_req.addr == OFS_IDENT_LO |=> cfg.identity[31:0] == $past(bus_req.wdata))
        else $error("identity low word not written");
    AST_IDENT_HI_WRITE: assert property (
        bus_req.wr && bus_req.addr == OFS_IDENT_HI |=> cfg.identity[63:32] == $past(bus_req.wdata))
        else $error("identity high word not written");
    AST_DOMAIN_WRITE: assert property (
        bus_req.wr && bus_req.addr == OFS_DOMAIN |=> cfg.domain == $past(bus_req.wdata[7:0]))
        else $error("domain not written");
    AST_SKEW_WRITE: assert property (
        bus_req.wr && bus_req.addr == OFS_SKEW |=> cfg.skew == $past(bus_req.wdata))
        else $error("skew not written");
    AST_LIMIT_WRITE: assert property (
        bus_req.wr && bus_req.addr == OFS_LIMIT |=> cfg.limit == $past(bus_req.wdata))
        else $error("limit not written");
    AST_LOG_WRITE: assert property (
        VARIABLE_RATE && bus_req.wr && bus_req.addr == OFS_LOG_PERIOD
        |=> cfg.log_period == $past(bus_req.wdata[7:0]))
        else $error("log interval not written");
    AST_INTV_PULSE: assert property (
        wr_port_ctrl && bus_req.wdata[BIT_INTV_VAL] |=> cfg.interval_load == VARIABLE_RATE)
        else $error("interval valid did not apply");
    AST_MECH_PULSE: assert property (
        wr_port_ctrl && bus_req.wdata[BIT_MECH_VAL] |=> cfg.mechanism_load)
        else $error("mechanism valid did not apply");
    AST_SKEW_PULSE: assert property (
        wr_port_ctrl && bus_req.wdata[BIT_SKEW_VAL] |=> cfg.skew_load)
        else $error("skew valid did not apply");
    AST_SKEW_LOAD_ONLY: assert property (cfg.skew_load |-> $past(wr_port_ctrl))
        else $error("skew load without control write");
    AST_IDENT_LOAD_ONLY: assert property (cfg.identity_load |-> $past(wr_def_ctrl))
        else $error("identity load without control write");
    AST_DOMAIN_LOAD_ONLY: assert property (cfg.domain_load |-> $past(wr_def_ctrl))
        else $error("domain load without control write");
    AST_DELAY_RO: assert property ($changed(st.delay) |-> $past(port_take))
        else $error("peer delay changed without snapshot");
    AST_DEF_CTRL_RESERVED: assert property (
        bus_req.rd && bus_req.addr == OFS_DEF_CTRL |=> bus_rdata[29:2] == 28'h0000000)
        else $error("default control reserved bits not zero");
    AST_PORT_CTRL_RESERVED: assert property (
        bus_req.rd && bus_req.addr == OFS_PORT_CTRL
        |=> bus_rdata[29:24] == 6'h00 && bus_rdata[15:3] == 13'h0000)
        else $error("port control reserved bits not zero");
    AST_LOG_RESERVED: assert property (
        bus_req.rd && bus_req.addr == OFS_LOG_PERIOD |=> bus_rdata[31:8] == 24'h000000)
        else $error("log interval reserved bits not zero");
    AST_DEF_DONE_READ: assert property (
        bus_req.rd && bus_req.addr == OFS_DEF_CTRL |=> bus_rdata[BIT_DONE] == $past(def_done))
        else $error("default done readback wrong");
    AST_PORT_DONE_READ: assert property (
        bus_req.rd && bus_req.addr == OFS_PORT_CTRL |=> bus_rdata[BIT_DONE] == $past(port_done))
        else $error("port done readback wrong");
    AST_RDATA_HOLD: assert property (!bus_req.rd |=> $stable(bus_rdata))
        else $error("read data changed without read");
    AST_SEL_READ: assert property (
        bus_req.rd && bus_req.addr == OFS_PORT_CTRL
        |=> bus_rdata[23:16] == $past(cfg.port_select))
        else $error("port select readback wrong");
    AST_IDENT_LO_READ: assert property (
        bus_req.rd && bus_req.addr == OFS_IDENT_LO |=> bus_rdata == $past(cfg.identity[31:0]))
        else $error("identity low readback wrong");
    AST_DELAY_HI_READ: assert property (
        bus_req.rd && bus_req.addr == OFS_DELAY_HI |=> bus_rdata == $past(st.delay[63:32]))
        else $error("peer delay high readback wrong");

    COV_DEF_SNAPSHOT: cover property (def_req ##2 def_done);
    COV_IDENT_APPLY: cover property (cfg.identity_load);
    COV_PORT_SNAPSHOT: cover property (port_req ##2 port_done);
endmodule : tcds_regs

/* test/tcds_tb.sv */
// Self-checking bench for the transparent clock dataset register bank.
// Assumes the bank alone, reached through its one-cycle strobe port on mclk.
`timescale 1ns/100ps
module tb;
    import tcds_pkg::*;

    localparam int PC = 5;

    logic          mclk            = 1'b0;
    logic          nrst            = 1'b0;
    tcds_bus_req_t bus_req         = '0;
    logic [31:0]   bus_rdata;
    logic          bus_ack;
    logic [63:0]   live_identity   = '0;
    logic [7:0]    live_domain     = '0;
    logic [63:0]   live_peer_delay = '0;
    logic [1:0]    profile         = '0;
    tcds_cfg_t     cfg;
    logic          peer_delay_ok;
    int            n_errors        = 0;
    int            total_checks    = 0;
    logic [31:0]   rv;
    logic [15:0]   dly;
    logic [15:0]   zofs [11];

    tcds_regs #(
        .PORT_COUNT    (PC),
        .VARIABLE_RATE (1'b1)
    ) uut (
        .mclk            (mclk),
        .nrst            (nrst),
        .bus_req         (bus_req),
        .bus_rdata       (bus_rdata),
        .bus_ack         (bus_ack),
        .live_identity   (live_identity),
        .live_domain     (live_domain),
        .live_peer_delay (live_peer_delay),
        .profile         (profile),
        .cfg             (cfg),
        .peer_delay_ok   (peer_delay_ok)
    );

    always #4 mclk = ~mclk;

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // One strobe cycle, then wait for the acknowledge
    task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
        #1;
        i = 0;
        while (bus_ack !== 1'b1 && i < 8) begin
            @(posedge mclk);
            #1;
            i++;
        end
        if (i == 8) begin
            n_errors++;
            tally_and_finish();
        end else begin
            rv = bus_rdata;
        end
    endtask : access

    task automatic wreg(input logic [15:0] a, input logic [31:0] d);
        access(1'b1, a, d);
    endtask : wreg

    // Poll a control word until its done flag reads one
    task automatic poll_done(input logic [15:0] a);
        int n;
        n = 0;
        access(1'b0, a, 32'h0);
        while (rv[BIT_DONE] !== 1'b1 && n < 8) begin
            access(1'b0, a, 32'h0);
            n++;
        end
        if (rv[BIT_DONE] !== 1'b1) begin
            n_errors++;
            tally_and_finish();
        end
    endtask : poll_done

    task automatic rreg(input logic [15:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0);
        chk(rv, exp);
    endtask : rreg

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        zofs = '{OFS_DEF_CTRL, OFS_IDENT_LO, OFS_IDENT_HI, OFS_DOMAIN, OFS_PORT_CTRL,
                 OFS_DELAY_HI, OFS_DELAY_LO, OFS_LOG_PERIOD, OFS_SKEW, OFS_LIMIT, 16'h1910};
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        #1;
        chk(peer_delay_ok, 1'b1);
        // Reset values, unmapped place and read-only count
        foreach (zofs[k]) rreg(zofs[k], 32'h0);
        rreg(OFS_PORT_COUNT, PC);
        wreg(OFS_PORT_COUNT, 32'hffff_ffff);
        rreg(OFS_PORT_COUNT, PC);
        wreg(16'h1910, 32'hffff_ffff);
        rreg(16'h1910, 32'h0);
        // Identity words first, valid bit after
        wreg(OFS_IDENT_LO, 32'hff33_2211);
        wreg(OFS_IDENT_HI, 32'h7766_55fe);
        wreg(OFS_DEF_CTRL, 32'h0000_0001);
        chk({cfg.identity_load, cfg.domain_load}, 2'h2);
        chk(cfg.identity, 64'h7766_55fe_ff33_2211);
        chk(cfg.mac, 48'h7766_5533_2211);
        rreg(OFS_DEF_CTRL, 32'h0);
        rreg(OFS_IDENT_LO, 32'hff33_2211);
        rreg(OFS_IDENT_HI, 32'h7766_55fe);
        wreg(OFS_DOMAIN, 32'h0000_01a5);
        wreg(OFS_DEF_CTRL, 32'h0000_0002);
        chk({cfg.identity_load, cfg.domain_load}, 2'h1);
        chk(cfg.domain, 8'ha5);
        rreg(OFS_DOMAIN, 32'h0000_00a5);
        // Default snapshot, twice with new live values
        for (int j = 0; j < 2; j++) begin
            live_identity <= j ? 64'hfedc_ba98_7654_3210 : 64'h0123_4567_89ab_cdef;
            live_domain   <= j ? 8'hc3 : 8'h3c;
            wreg(OFS_DEF_CTRL, 32'h4000_0000);
            poll_done(OFS_DEF_CTRL);
            chk(rv, 32'h8000_0000);
            rreg(OFS_IDENT_LO, j ? 32'h7654_3210 : 32'h89ab_cdef);
            rreg(OFS_IDENT_HI, j ? 32'hfedc_ba98 : 32'h0123_4567);
            rreg(OFS_DOMAIN, j ? 32'h0000_00c3 : 32'h0000_003c);
        end
        // Per-setting valid bits of the port
        for (int k = 0; k < 3; k++) begin
            wreg(OFS_PORT_CTRL, 32'h0001_0000 | (32'h1 << k));
            chk({cfg.skew_load, cfg.interval_load, cfg.mechanism_load}, 3'h1 << k);
            chk(cfg.port_select, 8'h01);
        end
        rreg(OFS_PORT_CTRL, 32'h0001_0000);
        // Port snapshot of the peer delay
        live_peer_delay <= 64'h1234_5678_9abc_def0;
        wreg(OFS_PORT_CTRL, 32'h4003_0000);
        poll_done(OFS_PORT_CTRL);
        chk(rv, 32'h8003_0000);
        rreg(OFS_DELAY_HI, 32'h1234_5678);
        rreg(OFS_DELAY_LO, 32'h9abc_def0);
        wreg(OFS_DELAY_LO, 32'h0);
        rreg(OFS_DELAY_LO, 32'h9abc_def0);
        // Writable port settings
        wreg(OFS_LOG_PERIOD, 32'hffff_ff81);
        rreg(OFS_LOG_PERIOD, 32'h0000_0081);
        chk(cfg.log_period, 8'h81);
        wreg(OFS_SKEW, 32'h8000_0001);
        rreg(OFS_SKEW, 32'h8000_0001);
        chk(cfg.skew, 32'h8000_0001);
        wreg(OFS_LIMIT, 32'h0000_0064);
        rreg(OFS_LIMIT, 32'h0000_0064);
        chk(cfg.limit, 32'h0000_0064);
        // Limit check at the boundary, under every profile code
        for (int j = 0; j < 2; j++) begin
            dly = 16'h0064 + 16'(j);
            live_peer_delay <= {16'h0, 16'h0, dly, 16'h0};
            wreg(OFS_PORT_CTRL, 32'h4003_0000);
            for (int p = 0; p < 4; p++) begin
                profile <= 2'(p);
                repeat (3) @(posedge mclk);
                #1;
                chk(peer_delay_ok, !(p == 3 && j == 1));
            end
        end
        // Reset again in mid-run
        nrst <= 1'b0;
        #20;
        chk(cfg.identity, 64'h0);
        chk(peer_delay_ok, 1'b1);
        @(posedge mclk);
        nrst <= 1'b1;
        rreg(OFS_SKEW, 32'h0);
        rreg(OFS_PORT_COUNT, PC);
        tally_and_finish();
    end
endmodule : tb
